/* File: design/vpcd_config_diag.v */
`timescale 1ns/1ps
`default_nettype none
`include "vpcd_consts.vh"

// Notes on behaviour
// - Redundancy select 0 means standalone, 1 means redundant operation.
// - Setting redundancy select switches the panel serial port to 25 kbaud.
// - Save command writes the configuration constants to nonvolatile memory, target position bits 8:0 only.
// - Demand loads target position, forces local mode, sets blocking restriction.
// - Release command clears the demand restriction so normal mode may resume.
// - Coil count 1: redundant pair, only servo coil 1 driven.
// - Coil count 2: coils 1 and 2 driven, coil 3 diagnostic off.
// - Coil open or short reported only after persisting the set milliseconds.
// - Status dump emits mode, restriction, signal and severe fault hex fields.
// - Mode codes: start 0x00-05, local 0x14-19, normal 0x28-2B, test 0x3C-3F.
// - Restriction bits 0-2: program checksum, memory diagnostic, converter.
// - Restriction bits 3-6: contingency, bus unconfigured, mismatch, no update.
// - Restriction bits 7-10: no tracking, nonvolatile checksum, oscillator, serial local.
// - Signal bits 0-2 coil diagnostics; bits 4-9 open/short pairs per coil.
// - Signal bits A-E: converter, contingency, repetitive display, raise, lower.
// - Severe bits 1-5: checksum, shared memory, processor memory, logic config, serial.
// - Severe bits 6-9: processor, converter, memory device, nonvolatile write sequence.
// - Position error over limit for deviation persist time is reported as contingency.
// - Panel bus address zero disables panel port; nonzero selects this module.
module vpcd_config_diag #(
  parameter MS_CYCLES = `VPCD_MS_CYCLES,
  parameter TW = 16
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire [15:0] cmd_arg_i,
  input wire [2:0] coil_open_i,
  input wire [2:0] coil_short_i,
  input wire deviation_over_i,
  input wire [8:0] ext_restrict_i,
  input wire [8:0] severe_err_i,
  input wire rep_display_i,
  input wire raise_button_i,
  input wire lower_button_i,
  input wire test_req_i,
  input wire dump_ready_i,
  output wire dump_valid_o,
  output reg [3:0] dump_digit_o,
  output reg [1:0] dump_field_o,
  output reg dump_last_o,
  output reg redundant_o,
  output reg panel_baud_25k_o,
  output reg panel_port_enable_o,
  output reg [7:0] panel_bus_address_o,
  output reg [2:0] coil_drive_en_o,
  output reg [2:0] coil_diag_en_o,
  output reg failover_o,
  output reg contingency_o,
  output reg [15:0] target_position_o,
  output reg [15:0] operating_mode_o,
  output reg nv_save_o,
  output reg [58:0] nv_image_o
);
  localparam ST_START = 4'h1;
  localparam ST_LOCAL = 4'h2;
  localparam ST_NORMAL = 4'h4;
  localparam ST_TEST = 4'h8;
  localparam NS = 28;

  // Pin inputs: two-stage synchroniser, nothing reads stage one
  wire [NS-1:0] pins = {coil_open_i, coil_short_i, deviation_over_i, ext_restrict_i,
    severe_err_i, rep_display_i, raise_button_i, lower_button_i};
  reg [NS-1:0] sync1;
  reg [NS-1:0] sync2;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      sync1 <= {NS{1'b0}};
      sync2 <= {NS{1'b0}};
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end
  wire [2:0] s_open = sync2[27:25];
  wire [2:0] s_short = sync2[24:22];
  wire s_dev = sync2[21];
  wire [8:0] s_restr = sync2[20:12];
  wire [8:0] s_severe = sync2[11:3];
  wire s_rep = sync2[2];
  wire s_raise = sync2[1];
  wire s_lower = sync2[0];
  // Test request has a flop pair of its own, outside the packed bus
  reg test1;
  reg test2;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      test1 <= 1'b0;
      test2 <= 1'b0;
    end else begin
      test1 <= test_req_i;
      test2 <= test1;
    end
  end

  // Millisecond timebase
  reg [31:0] ms_count;
  reg ms_tick;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      ms_count <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_count == MS_CYCLES - 1) begin
      ms_count <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_count <= ms_count + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // Configuration constants
  reg [1:0] coil_count;
  reg [TW-1:0] diag_time;
  reg [TW-1:0] dev_time;
  reg demand_restrict;
  wire cmd_redund = cmd_valid_i && (cmd_code_i == `VPCD_CMD_REDUNDANCY);
  wire cmd_coils = cmd_valid_i && (cmd_code_i == `VPCD_CMD_COIL_COUNT);
  wire cmd_diag = cmd_valid_i && (cmd_code_i == `VPCD_CMD_DIAG_TIME);
  wire cmd_devt = cmd_valid_i && (cmd_code_i == `VPCD_CMD_DEV_TIME);
  wire cmd_addr = cmd_valid_i && (cmd_code_i == `VPCD_CMD_PANEL_ADDR);
  wire cmd_save = cmd_valid_i && (cmd_code_i == `VPCD_CMD_SAVE);
  wire cmd_demand = cmd_valid_i && (cmd_code_i == `VPCD_CMD_DEMAND);
  wire cmd_release = cmd_valid_i && (cmd_code_i == `VPCD_CMD_RELEASE);
  wire cmd_dump = cmd_valid_i && (cmd_code_i == `VPCD_CMD_DUMP);

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      redundant_o <= `VPCD_RST_REDUNDANCY;
      panel_baud_25k_o <= 1'b0;
      coil_count <= `VPCD_RST_COIL_COUNT;
      diag_time <= `VPCD_RST_DIAG_TIME_MS;
      dev_time <= `VPCD_RST_DEV_TIME_MS;
      panel_bus_address_o <= `VPCD_RST_PANEL_ADDR;
      target_position_o <= `VPCD_RST_TARGET;
      demand_restrict <= 1'b0;
      nv_save_o <= 1'b0;
      nv_image_o <= 59'h0;
    end else begin
      if (cmd_redund) begin
        redundant_o <= cmd_arg_i[0] ? `VPCD_REDUNDANT : `VPCD_STANDALONE;
        panel_baud_25k_o <= 1'b1;
      end
      if (cmd_coils)
        coil_count <= cmd_arg_i[1:0];
      if (cmd_diag)
        diag_time <= cmd_arg_i[TW-1:0];
      if (cmd_devt)
        dev_time <= cmd_arg_i[TW-1:0];
      if (cmd_addr)
        panel_bus_address_o <= cmd_arg_i[7:0];
      if (cmd_demand) begin
        target_position_o <= cmd_arg_i;
        demand_restrict <= 1'b1;
      end else if (cmd_release) begin
        demand_restrict <= 1'b0;
      end
      // Image is frozen at the save strobe so the writer sees one coherent set
      nv_save_o <= cmd_save;
      if (cmd_save)
        nv_image_o <= {redundant_o, panel_baud_25k_o, coil_count, diag_time, dev_time,
          panel_bus_address_o, target_position_o[8:0], {(59 - 53){1'b0}}};
    end
  end

  // Coil usage
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      coil_drive_en_o <= 3'h0;
      coil_diag_en_o <= 3'h0;
      panel_port_enable_o <= 1'b0;
    end else begin
      panel_port_enable_o <= (panel_bus_address_o != 8'h00);
      case (coil_count)
        2'h1: begin
          coil_drive_en_o <= 3'h1;
          coil_diag_en_o <= 3'h1;
        end
        2'h2: begin
          coil_drive_en_o <= 3'h3;
          coil_diag_en_o <= 3'h3;
        end
        default: begin
          coil_drive_en_o <= 3'h7;
          coil_diag_en_o <= 3'h7;
        end
      endcase
    end
  end

  // Coil open/short persistence, one timer per flag
  wire [5:0] coil_raw;
  wire [5:0] coil_hit;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_coil
      assign coil_raw[2*g] = s_open[g] && coil_diag_en_o[g];
      assign coil_raw[2*g+1] = s_short[g] && coil_diag_en_o[g];
    end
    for (g = 0; g < 6; g = g + 1) begin : g_timer
      vpcd_persist_timer #(.W(TW)) u_coil (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .tick_i(ms_tick),
        .cond_i(coil_raw[g]),
        .limit_i(diag_time),
        .hit_o(coil_hit[g])
      );
    end
  endgenerate
  wire [2:0] coil_fail = {coil_hit[5] | coil_hit[4], coil_hit[3] | coil_hit[2], coil_hit[1] | coil_hit[0]};

  wire dev_hit;
  vpcd_persist_timer #(.W(TW)) u_dev (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .tick_i(ms_tick),
    .cond_i(s_dev),
    .limit_i(dev_time),
    .hit_o(dev_hit)
  );

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      failover_o <= 1'b0;
      contingency_o <= 1'b0;
    end else begin
      failover_o <= |coil_fail;
      contingency_o <= dev_hit;
    end
  end

  // Status words; unlisted bits stay zero
  reg [23:0] restr_word;
  reg [15:0] sig_word;
  reg [15:0] sev_word;
  always @* begin
    restr_word = 24'h0;
    restr_word[`VPCD_RB_PROM_CKSUM] = s_restr[0];
    restr_word[`VPCD_RB_MEM_DIAG] = s_restr[1];
    restr_word[`VPCD_RB_CONVERTER] = s_restr[2];
    restr_word[`VPCD_RB_CONTINGENCY] = contingency_o;
    restr_word[`VPCD_RB_IO_UNCONFIG] = s_restr[3];
    restr_word[`VPCD_RB_CONST_MISMATCH] = s_restr[4];
    restr_word[`VPCD_RB_CTRL_NO_UPDATE] = s_restr[5];
    restr_word[`VPCD_RB_CTRL_NO_TRACK] = s_restr[6];
    restr_word[`VPCD_RB_NV_CKSUM] = s_restr[7];
    restr_word[`VPCD_RB_OSC_WAIT] = s_restr[8];
    restr_word[`VPCD_RB_SERIAL_LOCAL] = demand_restrict;
    sig_word = 16'h0;
    sig_word[`VPCD_SB_COIL_DIAG +: 3] = coil_fail;
    sig_word[`VPCD_SB_COIL_FLAGS +: 6] = coil_hit;
    sig_word[`VPCD_SB_CONVERTER] = s_restr[2];
    sig_word[`VPCD_SB_CONTINGENCY] = contingency_o;
    sig_word[`VPCD_SB_REP_DISPLAY] = s_rep;
    sig_word[`VPCD_SB_RAISE] = s_raise;
    sig_word[`VPCD_SB_LOWER] = s_lower;
    sev_word = 16'h0;
    sev_word[`VPCD_FB_FIRST +: 5] = s_severe[4:0];
    sev_word[`VPCD_FB_FIRST + 5 +: 4] = s_severe[8:5];
  end

  // Operating mode; any restriction holds the unit out of normal
  reg [3:0] state;
  reg [3:0] next_state;
  wire blocked = |restr_word;
  always @* begin
    next_state = state;
    case (state)
      ST_START:
        if (test2)
          next_state = ST_TEST;
        else if (!restr_word[`VPCD_RB_OSC_WAIT])
          next_state = blocked ? ST_LOCAL : ST_NORMAL;
      ST_LOCAL:
        if (test2)
          next_state = ST_TEST;
        else if (!blocked)
          next_state = ST_NORMAL;
      ST_NORMAL:
        if (test2)
          next_state = ST_TEST;
        else if (blocked || cmd_demand)
          next_state = ST_LOCAL;
      ST_TEST:
        if (!test2)
          next_state = ST_START;
      default:
        next_state = ST_START;
    endcase
  end

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      state <= ST_START;
      operating_mode_o <= `VPCD_MODE_START;
    end else begin
      state <= next_state;
      case (next_state)
        ST_LOCAL: operating_mode_o <= `VPCD_MODE_LOCAL;
        ST_NORMAL: operating_mode_o <= `VPCD_MODE_NORMAL;
        ST_TEST: operating_mode_o <= `VPCD_MODE_TEST;
        default: operating_mode_o <= `VPCD_MODE_START;
      endcase
    end
  end

  // Status dump: words are snapshotted so the fields agree with each other
  reg [71:0] dump_shift;
  reg [4:0] dump_idx;
  reg dump_busy;
  assign dump_valid_o = dump_busy;
  wire dump_step = dump_busy && dump_ready_i;
  wire [4:0] next_idx = dump_idx + 5'h1;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      dump_shift <= 72'h0;
      dump_idx <= 5'h0;
      dump_busy <= 1'b0;
      dump_digit_o <= 4'h0;
      dump_field_o <= 2'h0;
      dump_last_o <= 1'b0;
    end else if (cmd_dump && !dump_busy) begin
      // First digit leaves at once; the shifter keeps the other 17 digits
      dump_shift <= {operating_mode_o[11:0], restr_word, sig_word, sev_word, 4'h0};
      dump_digit_o <= operating_mode_o[15:12];
      dump_idx <= 5'h0;
      dump_field_o <= 2'h0;
      dump_last_o <= 1'b0;
      dump_busy <= 1'b1;
    end else if (dump_step) begin
      if (next_idx == `VPCD_DUMP_DIGITS) begin
        dump_busy <= 1'b0;
        dump_last_o <= 1'b0;
      end else begin
        dump_digit_o <= dump_shift[71:68];
        dump_shift <= dump_shift << 4;
        dump_idx <= next_idx;
        dump_last_o <= (next_idx == `VPCD_DUMP_DIGITS - 5'h1);
        if (next_idx >= `VPCD_DUMP_END_SIG)
          dump_field_o <= 2'h3;
        else if (next_idx >= `VPCD_DUMP_END_RESTR)
          dump_field_o <= 2'h2;
        else if (next_idx >= `VPCD_DUMP_END_MODE)
          dump_field_o <= 2'h1;
        else
          dump_field_o <= 2'h0;
      end
    end
  end
endmodule // vpcd_config_diag

`default_nettype wire

/* File: inc/vpcd_consts.vh */
`ifndef VPCD_CONSTS_VH
`define VPCD_CONSTS_VH

// Command codes on the decoded command port
`define VPCD_CMD_REDUNDANCY 4'h1
`define VPCD_CMD_COIL_COUNT 4'h2
`define VPCD_CMD_DIAG_TIME 4'h3
`define VPCD_CMD_DEV_TIME 4'h4
`define VPCD_CMD_PANEL_ADDR 4'h5
`define VPCD_CMD_SAVE 4'h6
`define VPCD_CMD_DEMAND 4'h7
`define VPCD_CMD_RELEASE 4'h8
`define VPCD_CMD_DUMP 4'h9

// Reset values of the configuration constants
`define VPCD_RST_REDUNDANCY 1'h0
`define VPCD_RST_COIL_COUNT 2'h3
`define VPCD_RST_DIAG_TIME_MS 16'h0014
`define VPCD_RST_DEV_TIME_MS 16'h2710
`define VPCD_RST_PANEL_ADDR 8'h00
`define VPCD_RST_TARGET 16'h0000

// Redundancy select encodings
`define VPCD_STANDALONE 1'h0
`define VPCD_REDUNDANT 1'h1

// Operating mode word base values
`define VPCD_MODE_START 16'h0000
`define VPCD_MODE_LOCAL 16'h0014
`define VPCD_MODE_NORMAL 16'h0028
`define VPCD_MODE_TEST 16'h003c

// Restriction word bit positions
`define VPCD_RB_PROM_CKSUM 0
`define VPCD_RB_MEM_DIAG 1
`define VPCD_RB_CONVERTER 2
`define VPCD_RB_CONTINGENCY 3
`define VPCD_RB_IO_UNCONFIG 4
`define VPCD_RB_CONST_MISMATCH 5
`define VPCD_RB_CTRL_NO_UPDATE 6
`define VPCD_RB_CTRL_NO_TRACK 7
`define VPCD_RB_NV_CKSUM 8
`define VPCD_RB_OSC_WAIT 9
`define VPCD_RB_SERIAL_LOCAL 10

// Signal flag word bit positions
`define VPCD_SB_COIL_DIAG 0
`define VPCD_SB_COIL_FLAGS 4
`define VPCD_SB_CONVERTER 10
`define VPCD_SB_CONTINGENCY 11
`define VPCD_SB_REP_DISPLAY 12
`define VPCD_SB_RAISE 13
`define VPCD_SB_LOWER 14

// Severe fault word: external bits 0..8 land on bits 1..9
`define VPCD_FB_FIRST 1

// Timebase
`define VPCD_CLK_PERIOD_NS 4
`define VPCD_MS_NS 1000000
`define VPCD_MS_CYCLES (`VPCD_MS_NS / `VPCD_CLK_PERIOD_NS)

// Status dump: 4+6+4+4 hex digits
`define VPCD_DUMP_DIGITS 5'h12
`define VPCD_DUMP_END_MODE 5'h04
`define VPCD_DUMP_END_RESTR 5'h0a
`define VPCD_DUMP_END_SIG 5'h0e

`endif

/* File: design/vpcd_persist_timer.v */
`timescale 1ns/1ps
`default_nettype none

// Reports a condition only after it has held on every ms tick up to the limit.
module vpcd_persist_timer #(
  parameter W = 16
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire tick_i,
  input wire cond_i,
  input wire [W-1:0] limit_i,
  output reg hit_o
);
  reg [W-1:0] count;
  wire sat = &count;

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      count <= {W{1'b0}};
      hit_o <= 1'b0;
    end else begin
      // Any gap in the condition restarts the wait
      if (!cond_i)
        count <= {W{1'b0}};
      else if (tick_i && !sat)
        count <= count + {{(W-1){1'b0}}, 1'b1};
      hit_o <= cond_i && (count >= limit_i);
    end
  end
endmodule // vpcd_persist_timer

`default_nettype wire

/* File: test/vpcd_config_diag_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vpcd_consts.vh"
module vpcd_config_diag_checker (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [15:0] cmd_arg_i,
  input wire logic dump_ready_i,
  input wire logic dump_valid_o,
  input wire logic [3:0] dump_digit_o,
  input wire logic [1:0] dump_field_o,
  input wire logic dump_last_o,
  input wire logic redundant_o,
  input wire logic panel_baud_25k_o,
  input wire logic panel_port_enable_o,
  input wire logic [7:0] panel_bus_address_o,
  input wire logic [2:0] coil_drive_en_o,
  input wire logic [2:0] coil_diag_en_o,
  input wire logic [15:0] target_position_o,
  input wire logic [15:0] operating_mode_o,
  input wire logic nv_save_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  wire [3:0] op = cmd_valid_i ? cmd_code_i : 4'h0;

  AST_REDUNDANCY: assert property (op == `VPCD_CMD_REDUNDANCY |=> redundant_o == $past(cmd_arg_i[0]))
    else $error("redundancy select not applied");
  AST_BAUD: assert property (op == `VPCD_CMD_REDUNDANCY |=> panel_baud_25k_o)
    else $error("panel port rate not switched");
  AST_COIL_ONE: assert property (op == `VPCD_CMD_COIL_COUNT && cmd_arg_i[1:0] == 2'h1 |=> ##1
    coil_drive_en_o == 3'h1 && coil_diag_en_o == 3'h1) else $error("coil count one enables wrong");
  AST_COIL_TWO: assert property (op == `VPCD_CMD_COIL_COUNT && cmd_arg_i[1:0] == 2'h2 |=> ##1
    coil_drive_en_o == 3'h3 && coil_diag_en_o == 3'h3) else $error("coil count two enables wrong");
  AST_SAVE: assert property (op == `VPCD_CMD_SAVE |-> ##[1:2] nv_save_o)
    else $error("save pulse missing");
  AST_SAVE_PULSE: assert property (nv_save_o |-> $past(op == `VPCD_CMD_SAVE))
    else $error("save pulse without save command");
  AST_DEMAND: assert property (op == `VPCD_CMD_DEMAND |=> target_position_o == $past(cmd_arg_i))
    else $error("demand not loaded");
  AST_PORT: assert property (panel_port_enable_o == ($past(panel_bus_address_o) != 8'h00))
    else $error("panel port enable wrong");
  AST_DUMP_START: assert property (op == `VPCD_CMD_DUMP && !dump_valid_o |=> dump_valid_o && dump_field_o == 2'h0)
    else $error("dump did not start");
  AST_DUMP_HOLD: assert property (dump_valid_o && !dump_ready_i |=>
    dump_valid_o && $stable(dump_digit_o) && $stable(dump_field_o)) else $error("digit not held");
  AST_DUMP_LAST: assert property (dump_last_o |-> dump_valid_o && dump_field_o == 2'h3)
    else $error("last digit misplaced");
  AST_MODE: assert property (operating_mode_o inside {[16'h0000:16'h0005], [16'h0014:16'h0019],
    [16'h0028:16'h002b], [16'h003c:16'h003f]}) else $error("illegal mode code");

  cover property (op == `VPCD_CMD_DEMAND);
  cover property (dump_last_o && dump_ready_i);
  cover property ($rose(nv_save_o));
endmodule // vpcd_config_diag_checker

bind vpcd_config_diag vpcd_config_diag_checker u_chk (.clock_i, .reset_n_i, .cmd_valid_i, .cmd_code_i,
  .cmd_arg_i, .dump_ready_i, .dump_valid_o, .dump_digit_o, .dump_field_o, .dump_last_o, .redundant_o,
  .panel_baud_25k_o, .panel_port_enable_o, .panel_bus_address_o, .coil_drive_en_o, .coil_diag_en_o,
  .target_position_o, .operating_mode_o, .nv_save_o);
`default_nettype wire

/* File: test/vpcd_terminal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vpcd_terminal_model (
  input wire logic clock_i,
  input wire logic dump_valid_i,
  input wire logic [3:0] dump_digit_i,
  input wire logic dump_last_i,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [15:0] cmd_arg_o,
  output logic dump_ready_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_arg_o = 16'h0000;
    dump_ready_o = 1'b0;
  end
  task automatic send(input logic [3:0] code, input logic [15:0] arg);
    @(posedge clock_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    cmd_arg_o = arg;
    @(posedge clock_i);
    #1;
    cmd_valid_o = 1'b0;
    // Stale argument scrambled so a late sample cannot match by luck
    cmd_arg_o = ~arg;
  endtask
  // Stalls every other cycle to exercise the digit hold
  task automatic get_dump(output logic [71:0] v, output logic ok);
    int n;
    v = 72'h0;
    n = 0;
    ok = 1'b0;
    for (int c = 0; c < 200 && !ok; c++) begin
      @(posedge clock_i);
      if (dump_valid_i && dump_ready_o) begin
        v = {v[67:0], dump_digit_i};
        n++;
        ok = dump_last_i && n == 18;
      end
      #1;
      dump_ready_o = c[0];
    end
    dump_ready_o = 1'b0;
  endtask
endmodule // vpcd_terminal_model
`default_nettype wire

/* File: test/valve_positioner_config_diag_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vpcd_consts.vh"
module valve_positioner_config_diag_tb;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic test_req_i = 1'b0;
  logic rep_display_i = 1'b0;
  logic raise_button_i = 1'b0;
  logic lower_button_i = 1'b0;
  logic deviation_over_i = 1'b0;
  logic [2:0] coil_open_i = 3'h0;
  logic [2:0] coil_short_i = 3'h0;
  logic [8:0] ext_restrict_i = 9'h000;
  logic [8:0] severe_err_i = 9'h000;
  logic [71:0] dv;
  logic ok;
  int failures = 0;
  int samples_checked = 0;
  wire cmd_valid_i, dump_ready_i, dump_valid_o, dump_last_o, redundant_o, panel_baud_25k_o;
  wire panel_port_enable_o, failover_o, contingency_o, nv_save_o;
  wire [3:0] cmd_code_i, dump_digit_o;
  wire [1:0] dump_field_o;
  wire [15:0] cmd_arg_i, target_position_o, operating_mode_o;
  wire [7:0] panel_bus_address_o;
  wire [2:0] coil_drive_en_o, coil_diag_en_o;
  wire [58:0] nv_image_o;

  always #2 clock_i = ~clock_i;

  vpcd_terminal_model u_term (.clock_i(clock_i), .dump_valid_i(dump_valid_o), .dump_digit_i(dump_digit_o),
    .dump_last_i(dump_last_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_arg_o(cmd_arg_i),
    .dump_ready_o(dump_ready_i));
  vpcd_config_diag #(.MS_CYCLES(10)) u_dut (.clock_i, .reset_n_i, .cmd_valid_i, .cmd_code_i, .cmd_arg_i,
    .coil_open_i, .coil_short_i, .deviation_over_i, .ext_restrict_i, .severe_err_i, .rep_display_i,
    .raise_button_i, .lower_button_i, .test_req_i, .dump_ready_i, .dump_valid_o, .dump_digit_o, .dump_field_o,
    .dump_last_o, .redundant_o, .panel_baud_25k_o, .panel_port_enable_o, .panel_bus_address_o, .coil_drive_en_o,
    .coil_diag_en_o, .failover_o, .contingency_o, .target_position_o, .operating_mode_o, .nv_save_o, .nv_image_o);

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic dump;
    u_term.send(`VPCD_CMD_DUMP, 16'h0000);
    u_term.get_dump(dv, ok);
    chk(ok, 1'b1, "dump end");
    if (!ok)
      report_and_stop;
  endtask

  task automatic t_config;
    logic [2:0] en;
    wcyc(2);
    chk(redundant_o, `VPCD_STANDALONE, "reset redundancy");
    chk(panel_port_enable_o, 1'b0, "reset port");
    u_term.send(`VPCD_CMD_REDUNDANCY, 16'h0001);
    chk({redundant_o, panel_baud_25k_o}, 2'h3, "redundant");
    u_term.send(`VPCD_CMD_REDUNDANCY, 16'hfffe);
    chk({redundant_o, panel_baud_25k_o}, 2'h1, "standalone");
    for (int n = 1; n <= 3; n++) begin
      en = (n == 1) ? 3'h1 : (n == 2) ? 3'h3 : 3'h7;
      u_term.send(`VPCD_CMD_COIL_COUNT, 16'(n));
      wcyc(1);
      chk({coil_drive_en_o, coil_diag_en_o}, {en, en}, "coil enables");
    end
    u_term.send(`VPCD_CMD_PANEL_ADDR, 16'h005a);
    wcyc(1);
    chk({panel_bus_address_o, panel_port_enable_o}, 9'h0b5, "address set");
    u_term.send(`VPCD_CMD_PANEL_ADDR, 16'hff00);
    wcyc(1);
    chk(panel_port_enable_o, 1'b0, "address zero");
  endtask

  task automatic t_demand_save;
    wcyc(4);
    chk(operating_mode_o, `VPCD_MODE_NORMAL, "normal");
    u_term.send(`VPCD_CMD_DEMAND, 16'h1234);
    wcyc(2);
    chk({target_position_o, operating_mode_o}, {16'h1234, `VPCD_MODE_LOCAL}, "demand");
    dump;
    chk(dv[55:32], 24'h000400, "local restriction");
    u_term.send(`VPCD_CMD_RELEASE, 16'h0000);
    dump;
    chk(dv[55:32], 24'h000000, "released");
    u_term.send(`VPCD_CMD_DIAG_TIME, 16'h0003);
    u_term.send(`VPCD_CMD_DEV_TIME, 16'h0002);
    u_term.send(`VPCD_CMD_PANEL_ADDR, 16'h0021);
    u_term.send(`VPCD_CMD_SAVE, 16'h0000);
    for (int i = 0; i < 3 && !nv_save_o; i++)
      wcyc(1);
    chk(nv_save_o, 1'b1, "save pulse");
    chk(nv_image_o, {2'h1, 2'h3, 16'h0003, 16'h0002, 8'h21, 9'h034, 6'h00}, "image");
    wcyc(1);
    chk(nv_save_o, 1'b0, "save end");
  endtask

  task automatic t_status;
    for (int i = 0; i < 9; i++) begin
      ext_restrict_i = 9'h001 << i;
      severe_err_i = 9'h001 << i;
      wcyc(5);
      dump;
      chk(dv[71:56], `VPCD_MODE_LOCAL, "mode");
      chk(dv[55:32], 24'h000001 << ((i < 3) ? i : i + 1), "restriction");
      chk(dv[31:16], (i == 2) ? 16'h0400 : 16'h0000, "signals");
      chk(dv[15:0], 16'h0002 << i, "severe");
    end
    {ext_restrict_i, severe_err_i} = 18'h0;
    {rep_display_i, raise_button_i, lower_button_i, test_req_i} = 4'hf;
    wcyc(5);
    dump;
    chk(dv, {`VPCD_MODE_TEST, 24'h0, 16'h7000, 16'h0}, "test dump");
    {rep_display_i, raise_button_i, lower_button_i, test_req_i} = 4'h0;
    wcyc(8);
  endtask

  task automatic t_persist;
    int i;
    coil_short_i = 3'h4;
    wcyc(15);
    coil_short_i = 3'h0;
    wcyc(40);
    chk(failover_o, 1'b0, "short glitch");
    coil_open_i = 3'h2;
    for (i = 0; i < 60 && !failover_o; i++)
      wcyc(1);
    chk({failover_o, i >= 20}, 2'h3, "open report");
    dump;
    chk(dv[31:16], 16'h0042, "open flags");
    coil_open_i = 3'h0;
    deviation_over_i = 1'b1;
    wcyc(8);
    chk(contingency_o, 1'b0, "early deviation");
    for (i = 0; i < 40 && !contingency_o; i++)
      wcyc(1);
    chk(contingency_o, 1'b1, "deviation");
    dump;
    chk(dv[55:16], {24'h000008, 16'h0800}, "contingency flags");
    deviation_over_i = 1'b0;
  endtask

  initial begin
    wcyc(6);
    reset_n_i = 1'b1;
    t_config;
    t_demand_save;
    t_status;
    t_persist;
    report_and_stop;
  end
endmodule // valve_positioner_config_diag_tb
`default_nettype wire
